// ### rtl/pdc_map.svh
// register offsets, field positions and reset values of the divider configuration block
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH

// register byte offsets
`define PDC_ADDR_SHARED_FAST   8'h19
`define PDC_ADDR_OUT1_UPPER    8'h1F
`define PDC_ADDR_OUT1_MIDDLE   8'h20
`define PDC_ADDR_OUT1_LOWER    8'h21
`define PDC_ADDR_OUT2_UPPER    8'h22
`define PDC_ADDR_OUT2_MIDDLE   8'h23
`define PDC_ADDR_OUT2_LOWER    8'h24
`define PDC_ADDR_FB_UPPER      8'h28
`define PDC_ADDR_FB_MIDDLE     8'h29
`define PDC_ADDR_FB_LOWER      8'h2A

// writable bit masks of the mixed registers
`define PDC_MASK_NIBBLE        8'h0F
`define PDC_MASK_FB_UPPER      8'hEF
`define PDC_MASK_SHARED_FAST   8'hE0

// field positions
`define PDC_FAST_MSB           7
`define PDC_FAST_LSB           5

// reset values
`define PDC_RST_SHARED_FAST    8'h20
`define PDC_RST_OUT1_UPPER     8'h00
`define PDC_RST_OUT1_MIDDLE    8'h00
`define PDC_RST_OUT1_LOWER     8'h31
`define PDC_RST_OUT2_UPPER     8'h00
`define PDC_RST_OUT2_MIDDLE    8'h00
`define PDC_RST_OUT2_LOWER     8'h31
`define PDC_RST_FB_UPPER       8'hC0
`define PDC_RST_FB_MIDDLE      8'h00
`define PDC_RST_FB_LOWER       8'hF9

// fast divider code offset: code 0 divides by 4
`define PDC_FAST_BASE          4'h4

`endif

// ### rtl/pdc_pkg.sv
// types shared by the divider configuration block
package pdc_pkg;

    // register access request from the serial interface front end
    typedef struct packed {
        logic       wrEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } pdc_req_t;

    // decoded divide ratios applied to the clock path
    typedef struct packed {
        logic [3:0]  sharedOutputFastDiv;
        logic [19:0] outOneSlowDiv;
        logic [19:0] outTwoSlowDiv;
        logic [3:0]  feedbackFastDiv;
        logic [20:0] feedbackSlowDiv;
    } pdc_ratio_t;

    // reload sequencing of the ratio outputs
    typedef enum logic [1:0] {
        PDC_IDLE = 2'b01,
        PDC_LOAD = 2'b10
    } pdc_state_t;

endpackage

// ### rtl/pdc_divider_config.sv
// divider ratio register bank and ratio decode of the clock multiplier
//
// Contract
// - output one ratio from three registers, nibble high
// - output two ratio from three registers, nibble high
// - feedback fast code bits 7:5 gives 4..11
// - feedback slow bits 19:16 and 15:8 placed
// - feedback slow field encodes odd and even ratios alike; the code takes any value v as ratio v+1
// - feedback slow low byte in following register
// - shared output fast code 000..111 gives 4..11
`timescale 1ns/1ps
`include "pdc_map.svh"

module pdc_divider_config (
    // clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    // register access from the serial interface front end
    input wire pdc_pkg::pdc_req_t req,
    output logic [7:0] rdData,
    output logic addrHit,
    // applied divide ratios
    output pdc_pkg::pdc_ratio_t ratio,
    output logic ratioUpdate
);
    import pdc_pkg::*;

    // ------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------
    // shared output fast code, bits 7:5 only
    logic [7:0] sharedFast_q;
    logic [7:0] sharedFast_d;
    // output one ratio bytes: upper nibble, middle, lower
    logic [7:0] out1Up_q;
    logic [7:0] out1Up_d;
    logic [7:0] out1Mid_q;
    logic [7:0] out1Mid_d;
    logic [7:0] out1Lo_q;
    logic [7:0] out1Lo_d;
    // output two ratio bytes: upper nibble, middle, lower
    logic [7:0] out2Up_q;
    logic [7:0] out2Up_d;
    logic [7:0] out2Mid_q;
    logic [7:0] out2Mid_d;
    logic [7:0] out2Lo_q;
    logic [7:0] out2Lo_d;
    // feedback bytes: fast code with top nibble, middle, lower
    logic [7:0] fbUp_q;
    logic [7:0] fbUp_d;
    logic [7:0] fbMid_q;
    logic [7:0] fbMid_d;
    logic [7:0] fbLo_q;
    logic [7:0] fbLo_d;

    // writes merge through the writable mask so reserved bits keep zero
    // unmapped offsets fall through every branch and leave the bank untouched
    always_comb begin
        sharedFast_d = sharedFast_q;
        out1Up_d = out1Up_q;
        out1Mid_d = out1Mid_q;
        out1Lo_d = out1Lo_q;
        out2Up_d = out2Up_q;
        out2Mid_d = out2Mid_q;
        out2Lo_d = out2Lo_q;
        fbUp_d = fbUp_q;
        fbMid_d = fbMid_q;
        fbLo_d = fbLo_q;
        if (req.wrEn) begin
            if (req.addr == `PDC_ADDR_SHARED_FAST) begin
                sharedFast_d = req.wrData & `PDC_MASK_SHARED_FAST;
            end else if (req.addr == `PDC_ADDR_OUT1_UPPER) begin
                out1Up_d = req.wrData & `PDC_MASK_NIBBLE;
            end else if (req.addr == `PDC_ADDR_OUT1_MIDDLE) begin
                out1Mid_d = req.wrData;
            end else if (req.addr == `PDC_ADDR_OUT1_LOWER) begin
                out1Lo_d = req.wrData;
            end else if (req.addr == `PDC_ADDR_OUT2_UPPER) begin
                out2Up_d = req.wrData & `PDC_MASK_NIBBLE;
            end else if (req.addr == `PDC_ADDR_OUT2_MIDDLE) begin
                out2Mid_d = req.wrData;
            end else if (req.addr == `PDC_ADDR_OUT2_LOWER) begin
                out2Lo_d = req.wrData;
            end else if (req.addr == `PDC_ADDR_FB_UPPER) begin
                fbUp_d = req.wrData & `PDC_MASK_FB_UPPER;
            end else if (req.addr == `PDC_ADDR_FB_MIDDLE) begin
                fbMid_d = req.wrData;
            end else if (req.addr == `PDC_ADDR_FB_LOWER) begin
                fbLo_d = req.wrData;
            end
        end
    end

    // register storage, frozen while the clock enable is low
    // a write lands on an enabled edge and reads back from the next cycle on
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sharedFast_q <= `PDC_RST_SHARED_FAST;
            out1Up_q <= `PDC_RST_OUT1_UPPER;
            out1Mid_q <= `PDC_RST_OUT1_MIDDLE;
            out1Lo_q <= `PDC_RST_OUT1_LOWER;
            out2Up_q <= `PDC_RST_OUT2_UPPER;
            out2Mid_q <= `PDC_RST_OUT2_MIDDLE;
            out2Lo_q <= `PDC_RST_OUT2_LOWER;
            fbUp_q <= `PDC_RST_FB_UPPER;
            fbMid_q <= `PDC_RST_FB_MIDDLE;
            fbLo_q <= `PDC_RST_FB_LOWER;
        end else if (clkEn) begin
            sharedFast_q <= sharedFast_d;
            out1Up_q <= out1Up_d;
            out1Mid_q <= out1Mid_d;
            out1Lo_q <= out1Lo_d;
            out2Up_q <= out2Up_d;
            out2Mid_q <= out2Mid_d;
            out2Lo_q <= out2Lo_d;
            fbUp_q <= fbUp_d;
            fbMid_q <= fbMid_d;
            fbLo_q <= fbLo_d;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // combinational read; unmapped offsets read zero and drop addrHit
    // no wait states: the front end takes rdData in the cycle it shows the address
    always_comb begin
        rdData = 8'h00;
        addrHit = 1'b1;
        if (req.addr == `PDC_ADDR_SHARED_FAST) begin
            rdData = sharedFast_q;
        end else if (req.addr == `PDC_ADDR_OUT1_UPPER) begin
            rdData = out1Up_q;
        end else if (req.addr == `PDC_ADDR_OUT1_MIDDLE) begin
            rdData = out1Mid_q;
        end else if (req.addr == `PDC_ADDR_OUT1_LOWER) begin
            rdData = out1Lo_q;
        end else if (req.addr == `PDC_ADDR_OUT2_UPPER) begin
            rdData = out2Up_q;
        end else if (req.addr == `PDC_ADDR_OUT2_MIDDLE) begin
            rdData = out2Mid_q;
        end else if (req.addr == `PDC_ADDR_OUT2_LOWER) begin
            rdData = out2Lo_q;
        end else if (req.addr == `PDC_ADDR_FB_UPPER) begin
            rdData = fbUp_q;
        end else if (req.addr == `PDC_ADDR_FB_MIDDLE) begin
            rdData = fbMid_q;
        end else if (req.addr == `PDC_ADDR_FB_LOWER) begin
            rdData = fbLo_q;
        end else begin
            addrHit = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // ratio decode and reload
    // ------------------------------------------------------------
    // combinational decode of the register bank
    pdc_ratio_t ratioNext;
    // ratios as applied to the clock path
    pdc_ratio_t ratio_q;
    pdc_ratio_t ratio_d;
    // reload sequencer and its load pulse
    pdc_state_t state_q;
    pdc_state_t state_d;
    logic update_q;
    logic update_d;

    // output slow ratios pass through raw: zero means divide by one, and the
    // zero-or-odd limit is left to software, nothing here rejects an even value
    // field assembly; feedback slow value v divides by v+1, so 1 gives 2
    always_comb begin
        ratioNext.sharedOutputFastDiv = `PDC_FAST_BASE + {1'b0, sharedFast_q[`PDC_FAST_MSB:`PDC_FAST_LSB]};
        ratioNext.outOneSlowDiv = {out1Up_q[3:0], out1Mid_q, out1Lo_q};
        ratioNext.outTwoSlowDiv = {out2Up_q[3:0], out2Mid_q, out2Lo_q};
        ratioNext.feedbackFastDiv = `PDC_FAST_BASE + {1'b0, fbUp_q[`PDC_FAST_MSB:`PDC_FAST_LSB]};
        ratioNext.feedbackSlowDiv = {1'b0, fbUp_q[3:0], fbMid_q, fbLo_q} + 21'h000001;
    end

    // a change in any field loads the ratios two cycles later and pulses ratioUpdate,
    // so the clock path sees changes only on load edges, a half-written multi-byte value included
    // a write that lands during the load cycle differs again and starts a further load
    always_comb begin
        state_d = state_q;
        ratio_d = ratio_q;
        update_d = 1'b0;
        case (state_q)
            PDC_IDLE: begin
                if (ratioNext != ratio_q) begin
                    state_d = PDC_LOAD;
                end
            end
            PDC_LOAD: begin
                ratio_d = ratioNext;
                update_d = 1'b1;
                state_d = PDC_IDLE;
            end
            default: begin
                state_d = PDC_IDLE;
            end
        endcase
    end

    // ratio registers; they hold zero in reset, and the first load after release
    // pulses ratioUpdate, which tells the clock path when the settings are live
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= PDC_IDLE;
            ratio_q <= '0;
            update_q <= 1'b0;
        end else if (clkEn) begin
            state_q <= state_d;
            ratio_q <= ratio_d;
            update_q <= update_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // both straight from flip-flops, so the clock path sees no decode glitches
    assign ratio = ratio_q;
    assign ratioUpdate = update_q;

endmodule

// ### tb/pdc_divider_config_properties.sv
// concurrent checks on the ports of the divider configuration block
`timescale 1ns/1ps
module pdc_divider_config_properties (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    // register access
    input wire pdc_pkg::pdc_req_t req,
    input wire logic [7:0] rdData,
    input wire logic addrHit,
    // applied ratios
    input wire pdc_pkg::pdc_ratio_t ratio,
    input wire logic ratioUpdate
);
    import pdc_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // write taken, then two enabled edges, the first with no rewrite, so the load is sure to land
    sequence s_wr(logic [7:0] a);
        req.wrEn && clkEn && req.addr == a ##1 clkEn && !(req.wrEn && req.addr == a) ##1 clkEn;
    endsequence
    property p_hit;
        addrHit == (req.addr inside {8'h19, [8'h1F:8'h24], [8'h28:8'h2A]});
    endproperty
    a_hit: assert property (p_hit) else $error("address decode");
    property p_rsvd;
        !(((req.addr == 8'h1F || req.addr == 8'h22) && rdData[7:4] != 4'h0) || (req.addr == 8'h28 && rdData[4])
            || (req.addr == 8'h19 && rdData[4:0] != 5'h00));
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    // full bytes read back what was written one edge before
    property p_rdback;
        $past(req.wrEn && clkEn) && req.addr == $past(req.addr) && req.addr inside {8'h20, 8'h21, 8'h23, 8'h24, 8'h29, 8'h2A}
            |-> rdData == $past(req.wrData);
    endproperty
    a_rdback: assert property (p_rdback) else $error("read back");
    property p_out1;
        s_wr(8'h21) |=> ratio.outOneSlowDiv[7:0] == $past(req.wrData, 3);
    endproperty
    a_out1: assert property (p_out1) else $error("output one ratio");
    property p_fbfast;
        s_wr(8'h28) |=> ratio.feedbackFastDiv == 4'h4 + $past(req.wrData[7:5], 3);
    endproperty
    a_fbfast: assert property (p_fbfast) else $error("feedback fast ratio");
    property p_fbslow;
        s_wr(8'h2A) |=> ratio.feedbackSlowDiv[7:0] == $past(req.wrData, 3) + 8'h01;
    endproperty
    a_fbslow: assert property (p_fbslow) else $error("feedback slow ratio");
    property p_shared;
        s_wr(8'h19) |=> ratio.sharedOutputFastDiv == 4'h4 + $past(req.wrData[7:5], 3);
    endproperty
    a_shared: assert property (p_shared) else $error("shared fast ratio");
    property p_upd;
        $changed(ratio) |-> ratioUpdate;
    endproperty
    a_upd: assert property (p_upd) else $error("silent ratio change");
endmodule
bind pdc_divider_config pdc_divider_config_properties u_props (.clk(clk), .nrst(nrst), .clkEn(clkEn), .req(req),
    .rdData(rdData), .addrHit(addrHit), .ratio(ratio), .ratioUpdate(ratioUpdate));

// ### tb/pdc_divider_config_tb.sv
// self-checking bench of the divider configuration block
`timescale 1ns/1ps
module pdc_divider_config_tb;
    import pdc_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    pdc_req_t req = '0;
    logic [7:0] rdData;
    logic addrHit;
    pdc_ratio_t ratio;
    pdc_ratio_t ex;
    logic ratioUpdate;
    int err_count = 0;
    int checks_done = 0;
    // every mapped byte, then one unmapped place
    logic [7:0] adr [11] = '{8'h19, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h28, 8'h29, 8'h2A, 8'h25};
    logic [7:0] rstv [11] = '{8'h20, 8'h00, 8'h00, 8'h31, 8'h00, 8'h00, 8'h31, 8'hC0, 8'h00, 8'hF9, 8'h00};
    logic [7:0] msk [11] = '{8'hE0, 8'h0F, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hEF, 8'hFF, 8'hFF, 8'h00};
    logic [7:0] pat [11] = '{8'h60, 8'h0A, 8'hBC, 8'hD1, 8'h05, 8'h00, 8'h01, 8'h21, 8'h00, 8'h03, 8'h77};
    always #4 clk = ~clk;
    pdc_divider_config uut (.clk(clk), .nrst(nrst), .clkEn(clkEn), .req(req), .rdData(rdData),
        .addrHit(addrHit), .ratio(ratio), .ratioUpdate(ratioUpdate));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [68:0] exp, input logic [68:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    // write strobe stays up so back-to-back writes need no idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{1'b1, a, d};
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        req <= '{1'b0, a, 8'h00};
        #1;
        chk("rdData", 69'(exp), 69'(rdData));
        chk("addrHit", 69'(a != 8'h25), 69'(addrHit));
    endtask
    // bounded wait for the load pulse: two edges after the change, one cycle wide
    task automatic waitUpdate;
        int n;
        n = 0;
        while (ratioUpdate !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (ratioUpdate !== 1'b1) begin
            err_count++;
            tally_and_finish;
        end else begin
            chk("update latency", 69'(2), 69'(n));
            @(negedge clk);
            chk("ratioUpdate", 69'(0), 69'(ratioUpdate));
        end
    endtask
    initial begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        waitUpdate();
        ex = '{4'h5, 20'h00031, 20'h00031, 4'hA, 21'h000FA};
        chk("ratio", ex, ratio);
        for (int i = 0; i < 11; i++) rd(adr[i], rstv[i]);
        // all ones: reserved bits stay clear, feedback reaches its top ratio
        for (int i = 0; i < 11; i++) wr(adr[i], 8'hFF);
        for (int i = 0; i < 11; i++) rd(adr[i], msk[i]);
        ex = '{4'hB, 20'hFFFFF, 20'hFFFFF, 4'hB, 21'h100000};
        chk("ratio", ex, ratio);
        for (int i = 0; i < 11; i++) wr(adr[i], pat[i]);
        for (int i = 0; i < 11; i++) rd(adr[i], pat[i] & msk[i]);
        ex = '{4'h7, 20'hABCD1, 20'h50001, 4'h5, 21'h10004};
        chk("ratio", ex, ratio);
        // frozen clock enable must swallow the write
        @(negedge clk);
        clkEn = 1'b0;
        wr(8'h20, 8'h5A);
        rd(8'h20, 8'hBC);
        @(negedge clk);
        clkEn = 1'b1;
        wr(8'h21, 8'h33);
        rd(8'h21, 8'h33);
        waitUpdate();
        ex.outOneSlowDiv = 20'hABC33;
        chk("ratio", ex, ratio);
        tally_and_finish;
    end
endmodule
